// >>> shared/buck_pkg.sv
// package: constants, types and mode decoder for the buck mode control block
//
// How it works
// - decoded sleep control 0 means awake, 1 means in sleep
// - sleep control is the pin level, inverted when sleep_polarity_invert is 1
// - sleep request acts only in On; ignored in start-up and watchdog phase
// - low-power Off request reconfigures by mode fields and overrides sleep configuration
// - sleep_entry_delay 00 none, 01 one period (default), 10 two, 11 three
// - nonzero delay holds off the whole sleep response until the counter expires
// - delay applies on entering sleep only; leaving sleep is immediate
// - pin synchronisation may add up to one more 32 kHz period of latency
// - a regulator first switched on steps its output toward the programmed value
// - soft start forces PWM for 3.0 ms, then falls back to auto_skip
// - mode codes 0000 to 0111 decode to normal/sleep mode pairs
// - mode codes 1000 to 1111 decode to normal/sleep mode pairs
// - start-up sequencer reloads every buck_mode_select from the profile default
// - reading buck_mode_select returns the programmed value, not the effective mode
// - each regulator has a sleep set point defaulting to the profile normal set point
// - moves between normal and sleep set points follow a controlled slope
// - buck_memhold_mode bit picks off (0) or PFM (1) in memory hold
// - buck_useroff_mode bit picks off (0) or PFM (1) in user off
// - a regulator active in low-power Off uses its sleep set point until its sequencer slot in start-up
// - at its sequencer slot a regulator reloads as from Off; held ones stay on
package buck_pkg;

	// ****************************************
	// sizes and timing
	// ****************************************
	localparam int NUM_BUCK      = 5;
	localparam int CLK_MHZ       = 100;
	localparam int CLK_HZ        = 100_000_000;
	localparam int SLOW_HZ       = 32_768;
	localparam int TICK_CYC      = CLK_HZ / SLOW_HZ;     // one 32 kHz period, rounded down
	localparam int TICK_W        = 12;
	localparam int SOFT_START_US = 3000;                 // 3.0 ms forced PWM
	localparam int SOFT_START_CYC_DFLT = SOFT_START_US * CLK_MHZ;
	localparam int SS_W          = 20;

	// ****************************************
	// register map and fields
	// ****************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MODE   = 8'h08;
	localparam logic [7:0] OFS_LPMODE = 8'h0C;
	localparam logic [7:0] OFS_SETPT  = 8'h10;
	localparam int CTRL_INV_BIT   = 0;
	localparam int CTRL_DLY_LSB   = 1;
	localparam int CTRL_LPREQ_BIT = 3;
	localparam int LP_MH_LSB      = 0;
	localparam int LP_UO_LSB      = 8;
	localparam int SP_NORM_LSB    = 0;
	localparam int SP_SLEEP_LSB   = 8;

	// ****************************************
	// reset and profile defaults
	// ****************************************
	localparam logic       INV_RST  = 1'b0;
	localparam logic [1:0] DLY_RST  = 2'h1;
	localparam logic       LPREQ_RST = 1'b0;
	localparam logic [4:0] MH_RST   = 5'h00;
	localparam logic [4:0] UO_RST   = 5'h00;
	localparam logic [3:0] MODE_DFLT [4] = '{4'h8, 4'h5, 4'hC, 4'h1};
	localparam logic [5:0] VSET_DFLT [4] = '{6'h10, 6'h14, 6'h18, 6'h1C};

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {BM_OFF, BM_PWM, BM_PWM_SKIP, BM_PFM, BM_AUTO_SKIP} buck_mode_e;
	typedef enum logic [2:0] {
		PS_OFF, PS_STARTUP, PS_ON, PS_WATCHDOG, PS_MEMHOLD, PS_USEROFF
	} pwr_state_e;
	typedef struct packed {
		buck_mode_e mode;
		logic [5:0] vset;
	} buck_out_s;
	typedef struct packed {
		logic [25:0] pad;
		pwr_state_e  state;
		logic        pin_lvl;
		logic        sleep_act;
		logic        sleep_ctrl;
	} status_s;

	// normal or sleep column of a buck_mode_select code
	function automatic buck_mode_e mode_decode(input logic [3:0] code, input logic sleep);
		case (code)
			4'h0: mode_decode = BM_OFF;
			4'h1: mode_decode = sleep ? BM_OFF : BM_PWM;
			4'h2: mode_decode = sleep ? BM_OFF : BM_PWM_SKIP;
			4'h3: mode_decode = sleep ? BM_OFF : BM_PFM;
			4'h4: mode_decode = sleep ? BM_OFF : BM_AUTO_SKIP;
			4'h5: mode_decode = BM_PWM;
			4'h6: mode_decode = sleep ? BM_AUTO_SKIP : BM_PWM;
			4'h7: mode_decode = BM_OFF;
			4'h8: mode_decode = BM_AUTO_SKIP;
			4'h9: mode_decode = sleep ? BM_PWM_SKIP : BM_PWM;
			4'hA: mode_decode = BM_PWM_SKIP;
			4'hB: mode_decode = sleep ? BM_AUTO_SKIP : BM_PWM_SKIP;
			4'hC: mode_decode = sleep ? BM_PFM : BM_AUTO_SKIP;
			4'hD: mode_decode = sleep ? BM_PFM : BM_PWM;
			4'hE: mode_decode = sleep ? BM_PFM : BM_PWM_SKIP;
			default: mode_decode = BM_PFM;
		endcase
	endfunction : mode_decode

endpackage : buck_pkg

// >>> src/buck_channel.sv
// module: one regulator channel with soft start and set point slope
`timescale 1ns/1ns
module buck_channel #(
	parameter int unsigned SS_CYC = buck_pkg::SOFT_START_CYC_DFLT
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              tick,
	input  wire buck_pkg::buck_out_s tgt,
	output buck_pkg::buck_out_s    out
);
	import buck_pkg::*;

	typedef enum logic [1:0] {CH_OFF, CH_SOFT, CH_SKIP, CH_RUN} ch_state_e;

	ch_state_e        st_r;
	logic [SS_W-1:0]  ss_cnt_r;
	buck_mode_e       mode_r;
	logic [5:0]       vset_r;
	logic             tgt_on;

	assign tgt_on = (tgt.mode != BM_OFF);
	assign out    = '{mode: mode_r, vset: vset_r};

	// ****************************************
	// mode sequence: off, soft start, auto_skip, run
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r     <= CH_OFF;
			ss_cnt_r <= '0;
			mode_r   <= BM_OFF;
		end else begin
			case (st_r)
				CH_OFF: begin
					mode_r <= BM_OFF;
					if (tgt_on) begin
						st_r     <= CH_SOFT;
						ss_cnt_r <= SS_W'(SS_CYC - 1);
						mode_r   <= BM_PWM;
					end
				end
				CH_SOFT: begin
					if (!tgt_on) begin
						st_r   <= CH_OFF;
						mode_r <= BM_OFF;
					end else if (ss_cnt_r == '0) begin
						st_r   <= CH_SKIP;
						mode_r <= BM_AUTO_SKIP;
					end else begin
						ss_cnt_r <= ss_cnt_r - 1'b1;
					end
				end
				CH_SKIP: begin
					if (!tgt_on) begin
						st_r   <= CH_OFF;
						mode_r <= BM_OFF;
					end else if (vset_r == tgt.vset) begin
						st_r   <= CH_RUN;
						mode_r <= tgt.mode;
					end
				end
				CH_RUN: begin
					mode_r <= tgt.mode;
					if (!tgt_on)
						st_r <= CH_OFF;
				end
				default: begin
					st_r   <= CH_OFF;
					mode_r <= BM_OFF;
				end
			endcase
		end
	end

	// set point: one code per 32 kHz tick toward target, discharged when off
	always_ff @(posedge clk) begin
		if (srst)
			vset_r <= '0;
		else if (st_r == CH_OFF || !tgt_on)
			vset_r <= '0;
		else if (tick && vset_r < tgt.vset)
			vset_r <= vset_r + 6'h01;
		else if (tick && vset_r > tgt.vset)
			vset_r <= vset_r - 6'h01;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	soft_start_a: assert property (st_r == CH_OFF && tgt_on |=> mode_r == BM_PWM && vset_r == 6'h00)
		else $error("soft start did not force PWM from zero");
	skip_fallback_a: assert property (st_r == CH_SOFT && tgt_on && ss_cnt_r == '0 |=> mode_r == BM_AUTO_SKIP)
		else $error("no auto_skip after soft start");
	slope_step_a: assert property (st_r != CH_OFF && tgt_on && tick && vset_r < tgt.vset |=> vset_r == $past(vset_r) + 6'h01)
		else $error("set point did not step by one");
	slope_hold_a: assert property (st_r != CH_OFF && tgt_on && !tick |=> $stable(vset_r))
		else $error("set point moved between ticks");

endmodule : buck_channel

// >>> src/buck_mode_ctrl.sv
// module: buck mode and sleep control with its APB register slave
`timescale 1ns/1ns
module buck_mode_ctrl #(
	parameter int unsigned SOFT_START_CYC = buck_pkg::SOFT_START_CYC_DFLT
) (
	input  wire logic                              CLK_SYS,
	input  wire logic                              SRST,
	input  wire logic                              PSEL,
	input  wire logic                              PENABLE,
	input  wire logic                              PWRITE,
	input  wire logic [7:0]                        PADDR,
	input  wire logic [31:0]                       PWDATA,
	output logic [31:0]                            PRDATA,
	output logic                                   PREADY,
	output logic                                   PSLVERR,
	input  wire logic                              SLEEP_PIN,
	input  wire buck_pkg::pwr_state_e              PWR_STATE,
	input  wire logic [1:0]                        PROFILE_SEL,
	input  wire logic                              SEQ_START,
	input  wire logic [buck_pkg::NUM_BUCK-1:0]     SEQ_SLOT,
	output buck_pkg::buck_out_s [buck_pkg::NUM_BUCK-1:0] BUCK_OUT,
	output logic                                   SLEEP_ACTIVE,
	output logic                                   LOWPWR_OFF_REQ
);
	import buck_pkg::*;

	logic [TICK_W-1:0]     tick_cnt_r;
	logic                  tick_r;
	logic                  pin_s1_r;
	logic                  pin_s2_r;
	logic                  pin_q_r;
	logic                  sleep_ctrl;
	logic                  sleep_req;
	logic                  sleep_act_r;
	logic [1:0]            dly_cnt_r;
	logic                  inv_r;
	logic [1:0]            dly_r;
	logic                  lp_req_r;
	logic [4*NUM_BUCK-1:0] mode_sel_r;
	logic [NUM_BUCK-1:0]   mh_r;
	logic [NUM_BUCK-1:0]   uo_r;
	logic [5:0]            norm_sp [NUM_BUCK];
	logic [4:0]            slp_sp [NUM_BUCK];
	logic [31:0]           prdata_r;
	logic                  pready_r;
	logic                  pslverr_r;
	logic [31:0]           rd_data;
	logic                  rd_hit;
	logic [2:0]            sp_idx;
	logic                  setup;
	logic                  wr_go;
	status_s               status;

	assign PRDATA         = prdata_r;
	assign PREADY         = pready_r;
	assign PSLVERR        = pslverr_r;
	assign SLEEP_ACTIVE   = sleep_act_r;
	assign LOWPWR_OFF_REQ = lp_req_r;

	// ****************************************
	// 32 kHz time base
	// ****************************************
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r     <= 1'b0;
		end
	end

	// ****************************************
	// sleep pin path
	// ****************************************
	// two-stage synchroniser, then sampled on the 32 kHz tick
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			pin_s1_r <= 1'b0;
			pin_s2_r <= 1'b0;
		end else begin
			pin_s1_r <= SLEEP_PIN;
			pin_s2_r <= pin_s1_r;
		end
	end

	// tick sampling costs at most one more slow period
	always_ff @(posedge CLK_SYS) begin
		if (SRST)
			pin_q_r <= 1'b0;
		else if (tick_r)
			pin_q_r <= pin_s2_r;
	end

	// 1 means sleep, after polarity correction
	assign sleep_ctrl = pin_q_r ^ inv_r;
	// only honoured in On, and never against a low-power Off request
	assign sleep_req  = sleep_ctrl && (PWR_STATE == PS_ON) && !lp_req_r;

	// entry delay in slow periods; exit is immediate
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			sleep_act_r <= 1'b0;
			dly_cnt_r   <= 2'h0;
		end else if (!sleep_req) begin
			sleep_act_r <= 1'b0;
			dly_cnt_r   <= 2'h0;
		end else if (!sleep_act_r) begin
			if (dly_cnt_r >= dly_r)
				sleep_act_r <= 1'b1;
			else if (tick_r)
				dly_cnt_r <= dly_cnt_r + 2'h1;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	assign setup = PSEL && !PENABLE;
	assign wr_go = PSEL && PENABLE && PWRITE && pready_r && !pslverr_r;
	assign sp_idx = 3'((PADDR - OFS_SETPT) >> 2);

	always_comb begin
		status = '{pad: '0, state: PWR_STATE, pin_lvl: pin_q_r,
			sleep_act: sleep_act_r, sleep_ctrl: sleep_ctrl};
	end

	// read decode; the mode register shows what was written
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (PADDR)
			OFS_CTRL: begin
				rd_data[CTRL_INV_BIT]            = inv_r;
				rd_data[CTRL_DLY_LSB +: 2]       = dly_r;
				rd_data[CTRL_LPREQ_BIT]          = lp_req_r;
			end
			OFS_STATUS: rd_data = status;
			OFS_MODE:   rd_data[4*NUM_BUCK-1:0] = mode_sel_r;
			OFS_LPMODE: begin
				rd_data[LP_MH_LSB +: NUM_BUCK] = mh_r;
				rd_data[LP_UO_LSB +: NUM_BUCK] = uo_r;
			end
			default: begin
				// range test on the full address, so high offsets cannot alias
				if (PADDR >= OFS_SETPT && PADDR[1:0] == 2'h0
						&& PADDR < OFS_SETPT + 8'(4 * NUM_BUCK)) begin
					rd_data[SP_NORM_LSB +: 6]  = norm_sp[sp_idx];
					rd_data[SP_SLEEP_LSB +: 5] = slp_sp[sp_idx];
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	// zero-wait answer: data captured in setup, ready in access
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !rd_hit;
			if (setup)
				prdata_r <= (rd_hit && !PWRITE) ? rd_data : 32'h0000_0000;
		end
	end

	// control bits
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			inv_r    <= INV_RST;
			dly_r    <= DLY_RST;
			lp_req_r <= LPREQ_RST;
		end else if (wr_go && PADDR == OFS_CTRL) begin
			inv_r    <= PWDATA[CTRL_INV_BIT];
			dly_r    <= PWDATA[CTRL_DLY_LSB +: 2];
			lp_req_r <= PWDATA[CTRL_LPREQ_BIT];
		end
	end

	// mode fields, reloaded by the sequencer ahead of any write
	always_ff @(posedge CLK_SYS) begin
		if (SRST)
			mode_sel_r <= {NUM_BUCK{MODE_DFLT[0]}};
		else if (SEQ_START)
			mode_sel_r <= {NUM_BUCK{MODE_DFLT[PROFILE_SEL]}};
		else if (wr_go && PADDR == OFS_MODE)
			mode_sel_r <= PWDATA[4*NUM_BUCK-1:0];
	end

	// low-power Off mode bits
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mh_r <= MH_RST;
			uo_r <= UO_RST;
		end else if (wr_go && PADDR == OFS_LPMODE) begin
			mh_r <= PWDATA[LP_MH_LSB +: NUM_BUCK];
			uo_r <= PWDATA[LP_UO_LSB +: NUM_BUCK];
		end
	end

	// ****************************************
	// per-regulator control
	// ****************************************
	for (genvar i = 0; i < NUM_BUCK; i++) begin : g_buck
		logic       held_r;
		logic       slot_done_r;
		logic [3:0] code;
		buck_out_s  tgt;

		assign code = mode_sel_r[4*i +: 4];

		// set points; sleep default follows the profile normal value
		always_ff @(posedge CLK_SYS) begin
			if (SRST) begin
				norm_sp[i] <= VSET_DFLT[0];
				slp_sp[i]  <= VSET_DFLT[0][4:0];
			end else if (SEQ_START) begin
				norm_sp[i] <= VSET_DFLT[PROFILE_SEL];
				slp_sp[i]  <= VSET_DFLT[PROFILE_SEL][4:0];
			end else if (wr_go && PADDR == OFS_SETPT + 8'(4*i)) begin
				norm_sp[i] <= PWDATA[SP_NORM_LSB +: 6];
				slp_sp[i]  <= PWDATA[SP_SLEEP_LSB +: 5];
			end
		end

		// remembers a regulator left on through low-power Off
		always_ff @(posedge CLK_SYS) begin
			if (SRST) begin
				held_r      <= 1'b0;
				slot_done_r <= 1'b0;
			end else begin
				if (PWR_STATE == PS_MEMHOLD)
					held_r <= mh_r[i];
				else if (PWR_STATE == PS_USEROFF)
					held_r <= uo_r[i];
				else if (PWR_STATE == PS_OFF || SEQ_SLOT[i])
					held_r <= 1'b0;
				if (SEQ_START)
					slot_done_r <= 1'b0;
				else if (SEQ_SLOT[i])
					slot_done_r <= 1'b1;
			end
		end

		// target mode and set point for this regulator
		always_comb begin
			tgt = '{mode: BM_OFF, vset: norm_sp[i]};
			case (PWR_STATE)
				PS_MEMHOLD: begin
					tgt.mode = mh_r[i] ? BM_PFM : BM_OFF;
					tgt.vset = {1'b0, slp_sp[i]};
				end
				PS_USEROFF: begin
					tgt.mode = uo_r[i] ? BM_PFM : BM_OFF;
					tgt.vset = {1'b0, slp_sp[i]};
				end
				PS_ON, PS_WATCHDOG: begin
					tgt.mode = mode_decode(code, sleep_act_r);
					if (sleep_act_r)
						tgt.vset = {1'b0, slp_sp[i]};
				end
				PS_STARTUP: begin
					if (slot_done_r || SEQ_SLOT[i]) begin
						tgt.mode = mode_decode(code, 1'b0);
					end else if (held_r) begin
						tgt.mode = BM_PFM;
						tgt.vset = {1'b0, slp_sp[i]};
					end
				end
				default: tgt.mode = BM_OFF;
			endcase
		end

		buck_channel #(
			.SS_CYC (SOFT_START_CYC)
		) u_chan (
			.clk  (CLK_SYS),
			.srst (SRST),
			.tick (tick_r),
			.tgt  (tgt),
			.out  (BUCK_OUT[i])
		);

		// per-regulator target checks
		memhold_sel_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
			PWR_STATE == PS_MEMHOLD |-> tgt.mode == (mh_r[i] ? BM_PFM : BM_OFF))
			else $error("memory hold mode not taken from its bit");
		useroff_sel_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
			PWR_STATE == PS_USEROFF |-> tgt.mode == (uo_r[i] ? BM_PFM : BM_OFF)
				&& tgt.vset == {1'b0, slp_sp[i]})
			else $error("user off mode or set point wrong");
		sleep_sp_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
			PWR_STATE == PS_ON && sleep_act_r |-> tgt.vset == {1'b0, slp_sp[i]})
			else $error("sleep does not use sleep set point");
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	// sleep path: entry, exit, gating and sampling; sequencer reload of the mode field
	sleep_exit_a: assert property (sleep_act_r && !sleep_req |=> !sleep_act_r)
		else $error("sleep exit was delayed");
	sleep_gate_a: assert property (PWR_STATE != PS_ON |=> !sleep_act_r)
		else $error("sleep taken outside On");
	no_delay_a: assert property (sleep_req && dly_r == 2'h0 && !sleep_act_r |=> sleep_act_r)
		else $error("zero delay did not enter sleep at once");
	hold_off_a: assert property ($rose(sleep_req) && dly_r != 2'h0 |=> !sleep_act_r)
		else $error("sleep entered before delay expired");
	count_hold_a: assert property (sleep_req && !sleep_act_r && dly_cnt_r < dly_r |=> !sleep_act_r)
		else $error("sleep entered with delay count short");
	lp_priority_a: assert property (lp_req_r |=> !sleep_act_r)
		else $error("sleep active under low-power Off request");
	polarity_a: assert property (pin_q_r == inv_r |=> !sleep_act_r)
		else $error("sleep taken with awake pin level");
	pin_sample_a: assert property (tick_r |=> pin_q_r == $past(pin_s2_r))
		else $error("pin not sampled on the slow tick");
	reload_a: assert property (SEQ_START |=> mode_sel_r[3:0] == MODE_DFLT[$past(PROFILE_SEL)])
		else $error("mode field not reloaded");

	// register slave answers
	read_mode_a: assert property (setup && !PWRITE && PADDR == OFS_MODE
		|=> PRDATA[4*NUM_BUCK-1:0] == $past(mode_sel_r))
		else $error("mode read differs from programmed value");
	apb_ready_a: assert property (setup |=> PREADY ##1 !PREADY)
		else $error("answer not one cycle after setup");
	bad_addr_a: assert property (setup && !rd_hit |=> PSLVERR && PRDATA == 32'h0000_0000)
		else $error("unmapped address not refused");

	// main scenarios
	sleep_delay3_c: cover property (dly_r == 2'h3 && $rose(sleep_act_r));
	memhold_on_c: cover property (PWR_STATE == PS_MEMHOLD && mh_r[0]);
	bad_addr_c: cover property (PREADY && PSLVERR);
	lp_block_c: cover property (lp_req_r && sleep_ctrl && PWR_STATE == PS_ON);
	seq_reload_c: cover property (SEQ_START && PROFILE_SEL != 2'h0);

endmodule : buck_mode_ctrl

// >>> bench/sleep_host.sv
// host side model: drives the sleep request pin
`timescale 1ns/1ns
module sleep_host (
	input  wire logic clk,
	input  wire logic want,
	input  wire logic inv,
	output logic      pin
);
	// the pin follows the request one clock after the bench sets it
	always @(posedge clk) begin
		pin <= want ^ inv;
	end
endmodule : sleep_host

// >>> bench/testbench.sv
// testbench: registers, sleep path and regulator outputs of buck_mode_ctrl
`timescale 1ns/1ns
module testbench;
	import buck_pkg::*;
	// ****************************************
	// signals and design
	// ****************************************
	localparam int SS = 20;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic        ee;
	} row_s;
	logic clk_sys = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic seq_start = 1'h0, want = 1'h0, inv = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0] prof = 2'h0;
	logic [NUM_BUCK-1:0] slot = '0;
	pwr_state_e pstate = PS_ON;
	wire [31:0] prdata;
	wire pready, pslverr, sleep_pin, sleep_act, lp_req;
	buck_out_s [NUM_BUCK-1:0] bout;
	int n_mismatch = 0;
	int samples_checked = 0;
	// ordinary register cases: reset values, readback, refused addresses
	localparam row_s ROWS [13] = '{
		'{1'h0, 8'h00, 32'h0, 32'h2, 1'h0}, '{1'h0, 8'h08, 32'h0, 32'h88888, 1'h0},
		'{1'h0, 8'h0C, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h10, 32'h0, 32'h1010, 1'h0},
		'{1'h0, 8'h20, 32'h0, 32'h1010, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h10, 1'h0},
		'{1'h1, 8'h08, 32'h12345, 32'h0, 1'h0}, '{1'h0, 8'h08, 32'h0, 32'h12345, 1'h0},
		'{1'h1, 8'h14, 32'h0A2A, 32'h0, 1'h0}, '{1'h0, 8'h14, 32'h0, 32'h0A2A, 1'h0},
		'{1'h0, 8'h40, 32'h0, 32'h0, 1'h1}, '{1'h1, 8'h02, 32'h1, 32'h0, 1'h1},
		'{1'h0, 8'h00, 32'h0, 32'h2, 1'h0}};

	always #5 clk_sys = ~clk_sys;

	buck_mode_ctrl #(.SOFT_START_CYC(SS)) u_dut (.CLK_SYS(clk_sys), .SRST(srst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SLEEP_PIN(sleep_pin),
		.PWR_STATE(pstate), .PROFILE_SEL(prof), .SEQ_START(seq_start), .SEQ_SLOT(slot),
		.BUCK_OUT(bout), .SLEEP_ACTIVE(sleep_act), .LOWPWR_OFF_REQ(lp_req));
	sleep_host u_host (.clk(clk_sys), .want(want), .inv(inv), .pin(sleep_pin));

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk32

	task automatic chk1(input logic g, input logic e);
		chk32({31'h0, g}, {31'h0, e});
	endtask : chk1

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] e, input logic ee);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'h1 && n < 20);
		chk1(pready, 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		chk1(pslverr, ee);
		if (!w) chk32(prdata, e);
	endtask : apb

	// bounded wait for the sleep flag to reach a level
	task automatic wait_sa(input logic lvl, input int maxc, output int n);
		n = 0;
		while (sleep_act !== lvl && n < maxc) begin
			@(posedge clk_sys);
			n++;
		end
	endtask : wait_sa

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		int n;
		repeat (6) @(posedge clk_sys);
		srst <= 1'h0;
		foreach (ROWS[i]) apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, ROWS[i].e, ROWS[i].ee);
		// entry latency for every delay code, exit without delay
		for (int d = 0; d < 4; d++) begin
			apb(1'h1, OFS_CTRL, 32'(d) << 1, 32'h0, 1'h0);
			want <= 1'h1;
			wait_sa(1'h1, (d + 1) * TICK_CYC + 9, n);
			chk1(n >= d * TICK_CYC && n <= (d + 1) * TICK_CYC + 8, 1'h1);
			apb(1'h0, OFS_MODE, 32'h0, 32'h12345, 1'h0);
			want <= 1'h0;
			wait_sa(1'h0, TICK_CYC + 9, n);
			chk1(n <= TICK_CYC + 6, 1'h1);
		end
		// inverted polarity: high pin means awake; level settles before the bit flips
		inv <= 1'h1;
		repeat (TICK_CYC + 6) @(posedge clk_sys);
		apb(1'h1, OFS_CTRL, 32'h3, 32'h0, 1'h0);
		wait_sa(1'h1, 2 * TICK_CYC + 9, n);
		chk1(sleep_act, 1'h0);
		want <= 1'h1;
		wait_sa(1'h1, 2 * TICK_CYC + 9, n);
		chk1(sleep_act, 1'h1);
		// outside the on state the request is ignored
		pstate <= PS_STARTUP;
		wait_sa(1'h0, 6, n);
		chk1(sleep_act, 1'h0);
		pstate <= PS_WATCHDOG;
		wait_sa(1'h1, 2 * TICK_CYC + 9, n);
		chk1(sleep_act, 1'h0);
		pstate <= PS_ON;
		wait_sa(1'h1, 2 * TICK_CYC + 9, n);
		chk1(sleep_act, 1'h1);
		// low-power off request overrides sleep
		apb(1'h1, OFS_CTRL, 32'hB, 32'h0, 1'h0);
		wait_sa(1'h0, 6, n);
		chk1(sleep_act, 1'h0);
		chk1(lp_req, 1'h1);
		want <= 1'h0;
		apb(1'h1, OFS_CTRL, 32'h3, 32'h0, 1'h0);
		// sequencer reload from profile 1, then soft start of regulator 0
		prof <= 2'h1;
		pstate <= PS_STARTUP;
		seq_start <= 1'h1;
		@(posedge clk_sys);
		seq_start <= 1'h0;
		apb(1'h0, OFS_MODE, 32'h0, 32'h55555, 1'h0);
		apb(1'h0, OFS_SETPT, 32'h0, 32'h1414, 1'h0);
		apb(1'h1, OFS_SETPT, 32'h0114, 32'h0, 1'h0);
		apb(1'h1, OFS_LPMODE, 32'h0201, 32'h0, 1'h0);
		slot <= 5'h01;
		@(posedge clk_sys);
		slot <= 5'h00;
		repeat (2) @(posedge clk_sys);
		chk32({23'h0, bout[0]}, {23'h0, BM_PWM, 6'h00});
		repeat (SS + 5) @(posedge clk_sys);
		chk32({29'h0, bout[0].mode}, {29'h0, BM_AUTO_SKIP});
		// memory hold and user off pick pfm or off per regulator
		pstate <= PS_MEMHOLD;
		n = 0;
		while (bout[0] !== {BM_PFM, 6'h01} && n < 2 * TICK_CYC + 9) begin
			@(posedge clk_sys);
			n++;
		end
		chk32({23'h0, bout[0]}, {23'h0, BM_PFM, 6'h01});
		chk32({29'h0, bout[1].mode}, {29'h0, BM_OFF});
		pstate <= PS_USEROFF;
		repeat (3) @(posedge clk_sys);
		chk32({29'h0, bout[0].mode}, {29'h0, BM_OFF});
		chk1(bout[1].mode !== BM_OFF, 1'h1);
		// a held regulator stays on when the sequencer starts
		pstate <= PS_STARTUP;
		seq_start <= 1'h1;
		@(posedge clk_sys);
		seq_start <= 1'h0;
		repeat (3) @(posedge clk_sys);
		chk1(bout[1].mode !== BM_OFF, 1'h1);
		wrap_up;
	end

	// watchdog against a hung wait
	initial begin
		repeat (90000) @(posedge clk_sys);
		n_mismatch++;
		wrap_up;
	end
endmodule : testbench
